//--- shared/cct_pkg.sv
/*
 * constants, register map and mode codes shared by the capture/compare
 * timer block. assumes an 8-bit register port with byte-wide registers.
 */
`default_nettype none

package cct_pkg;

    localparam int unsigned CH_N = 2;        // number of channels

    // register offsets on the plain register port
    localparam logic [7:0] A_FLAGS   = 8'h0C;
    localparam logic [7:0] A_FLAGS2  = 8'h0D;
    localparam logic [7:0] A_CNT_LO  = 8'h0E;
    localparam logic [7:0] A_CNT_HI  = 8'h0F;
    localparam logic [7:0] A_TCTL    = 8'h10;
    localparam logic [7:0] A_CH1_CTL = 8'h17;
    localparam logic [7:0] A_CH2_CTL = 8'h1D;
    localparam logic [7:0] A_CH1_VLO = 8'h20;
    localparam logic [7:0] A_CH1_VHI = 8'h21;
    localparam logic [7:0] A_CH2_VLO = 8'h22;
    localparam logic [7:0] A_CH2_VHI = 8'h23;
    localparam logic [7:0] A_DIR     = 8'h24;
    localparam logic [7:0] A_LATCH   = 8'h25;
    localparam logic [7:0] A_EN      = 8'h8C;
    localparam logic [7:0] A_EN2     = 8'h8D;

    // per-channel address and bit tables, index 0 is channel one
    localparam logic [1:0][7:0] CH_CTL_A  = {A_CH2_CTL, A_CH1_CTL};
    localparam logic [1:0][7:0] CH_VLO_A  = {A_CH2_VLO, A_CH1_VLO};
    localparam logic [1:0][7:0] CH_VHI_A  = {A_CH2_VHI, A_CH1_VHI};
    localparam logic [1:0][7:0] CH_FLG_A  = {A_FLAGS2, A_FLAGS};
    localparam logic [1:0][7:0] CH_EN_A   = {A_EN2, A_EN};
    localparam logic [1:0][2:0] CH_FLG_B  = {3'h0, 3'h2};

    // field positions
    localparam int unsigned FLG_TOVF = 0;    // timer overflow flag bit
    localparam int unsigned TC_RUN   = 0;    // timer run bit
    localparam int unsigned TC_SRC   = 1;    // clock source select bit
    localparam int unsigned TC_PS    = 4;    // prescale select, 2 bits
    localparam int unsigned CT_DUTY  = 4;    // duty lsbs, 2 bits

    // reset and fill values
    localparam logic [7:0]  R_ZERO   = 8'h00;
    localparam logic [5:0]  R_CTL    = 6'h00;
    localparam logic [1:0]  R_DIR    = 2'h3; // pins start as inputs
    localparam logic [15:0] CNT_TOP  = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // channel mode codes
    localparam logic [3:0] M_OFF      = 4'h0;
    localparam logic [3:0] M_CAP_FALL = 4'h4;
    localparam logic [3:0] M_CAP_RISE = 4'h5;
    localparam logic [3:0] M_CAP_R4   = 4'h6;
    localparam logic [3:0] M_CAP_R16  = 4'h7;
    localparam logic [3:0] M_CMP_SET  = 4'h8;
    localparam logic [3:0] M_CMP_CLR  = 4'h9;
    localparam logic [3:0] M_CMP_SW   = 4'hA;
    localparam logic [3:0] M_CMP_SPEC = 4'hB;

    // edge prescaler terminal counts
    localparam logic [3:0] EDGE_4    = 4'h3;
    localparam logic [3:0] EDGE_16   = 4'hF;

    // channel function class, one-hot
    typedef enum logic [3:0] {
        CCT_FN_OFF = 4'b0001,
        CCT_FN_CAP = 4'b0010,
        CCT_FN_CMP = 4'b0100,
        CCT_FN_PWM = 4'b1000
    } cct_fn_t;

    // class of a mode code
    function automatic cct_fn_t cct_fn_of(input logic [3:0] mode);
        cct_fn_t fn;
        fn = CCT_FN_OFF;
        case (mode[3:2])
            2'b01:   fn = CCT_FN_CAP;
            2'b10:   fn = CCT_FN_CMP;
            2'b11:   fn = CCT_FN_PWM;
            default: fn = CCT_FN_OFF;
        endcase
        return fn;
    endfunction : cct_fn_of

endpackage : cct_pkg

`default_nettype wire

//--- core/cct_pin_sync.sv
/*
 * three-stage synchroniser with edge detection for a pin input.
 * assumes the pin is asynchronous to clock_i; a change counts once
 * the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none

module cct_pin_sync
    import cct_pkg::*;
(
    input  wire logic clock_i,   // core clock
    input  wire logic rst_n_i,   // sync reset, active low
    input  wire logic pin_i,     // raw pin level
    output logic      rise_o,    // one-cycle rising edge
    output logic      fall_o     // one-cycle falling edge
);

    logic s1_q;      // first stage, read only by s2_q
    logic s2_q;      // second stage
    logic s3_q;      // third stage
    logic stable_q;  // last agreed level
    logic agree;     // stages two and three match

    // shift chain; reset value is arbitrary but defined
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign agree = (s2_q == s3_q);

    // agreed level only moves when both late stages match
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            stable_q <= 1'b0;
        else if (agree)
            stable_q <= s3_q;
    end

    assign rise_o = agree && s3_q && !stable_q;
    assign fall_o = agree && !s3_q && stable_q;

endmodule : cct_pin_sync

`default_nettype wire

//--- core/cct_edge_presc.sv
/*
 * capture event selector with edge-count prescaler for one channel.
 * assumes rise/fall pulses already synchronised to clock_i.
 */
`timescale 1ns/1ps
`default_nettype none

module cct_edge_presc
    import cct_pkg::*;
(
    input  wire logic       clock_i,  // core clock
    input  wire logic       rst_n_i,  // sync reset, active low
    input  wire logic [3:0] mode_i,   // channel mode field
    input  wire logic       rise_i,   // synced rising edge
    input  wire logic       fall_i,   // synced falling edge
    output logic            event_o   // capture event pulse
);

    logic [3:0] cnt_q;    // rising edges seen so far
    logic [3:0] mode_q;   // mode of previous cycle
    logic       multi;    // every 4th or 16th mode
    logic       term;     // terminal count reached

    assign multi = (mode_i == M_CAP_R4) || (mode_i == M_CAP_R16);
    assign term  = (mode_i == mode_q) && ((mode_i == M_CAP_R4) ? (cnt_q == EDGE_4)
                                                                : (cnt_q == EDGE_16));

    // event selection per capture mode
    always_comb
    begin
        case (mode_i)
            M_CAP_FALL: event_o = fall_i;
            M_CAP_RISE: event_o = rise_i;
            M_CAP_R4:   event_o = rise_i && term;
            M_CAP_R16:  event_o = rise_i && term;
            default:    event_o = 1'b0;
        endcase
    end

    // counts only rising edges, restarts on any mode change or when off
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q  <= 4'h0;
            mode_q <= M_OFF;
        end
        else
        begin
            mode_q <= mode_i;
            if (mode_i != mode_q || mode_i == M_OFF)
                cnt_q <= 4'h0;
            else if (rise_i && multi)
                cnt_q <= term ? 4'h0 : cnt_q + 4'h1;
        end
    end

endmodule : cct_edge_presc

`default_nettype wire

//--- core/cct_top.sv
/*
 * two capture/compare channels and the 16-bit timer they sample or
 * reset, with their register file. assumes a plain register port with
 * one-cycle strobes, and pins that are asynchronous to clock_i.
 */
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module cct_top
    import cct_pkg::*;
(
    input  wire logic             clock_i,     // core clock
    input  wire logic             rst_n_i,     // power-on/brown-out
    input  wire logic             oth_rst_i,   // any other reset
    input  wire logic [7:0]       addr_i,      // register address
    input  wire logic [7:0]       wdata_i,     // write data
    input  wire logic             wr_i,        // write strobe
    input  wire logic             rd_i,        // read strobe
    output logic      [7:0]       rdata_o,     // read data
    input  wire logic             t_ext_i,     // external timer clock
    input  wire logic [CH_N-1:0]  ch_pin_i,    // channel pin level
    output logic      [CH_N-1:0]  ch_pin_o,    // channel pin drive
    output logic      [CH_N-1:0]  ch_pin_oe_o  // channel pin enable
);

    // timer state
    logic [15:0]     cnt_q;       // 16-bit count, never reset
    logic [2:0]      psc_q;       // timer prescaler counter
    logic [5:0]      tctl_q;      // timer control
    logic            tovf_q;      // timer overflow flag
    logic            tovf_en_q;   // overflow enable, storage only

    // per-channel state
    logic [5:0]      ctl_q  [CH_N];  // duty lsbs and mode
    logic [15:0]     val_q  [CH_N];  // capture/compare pair
    logic [CH_N-1:0] flag_q;         // channel flags
    logic [CH_N-1:0] en_q;           // channel enables
    logic [CH_N-1:0] out_q;          // compare output state
    logic [CH_N-1:0] match_q;        // match seen last cycle
    logic [1:0]      dir_q;          // 1 = pin is input
    logic [1:0]      latch_q;        // port output latch

    // port registers
    logic [7:0]      rdata_q;     // registered read data
    logic [CH_N-1:0] pin_q;       // registered pin drive
    logic [CH_N-1:0] oe_q;        // registered pin enable

    // combinational helpers
    logic            any_rst;     // power-on or other reset
    logic            wr_lo;       // count low byte write
    logic            wr_hi;       // count high byte write
    logic            ext_rise;    // synced external clock edge
    logic            raw_evt;     // event before prescale
    logic [2:0]      ps_mask;     // prescaler terminal mask
    logic            psc_hit;     // prescaler terminal count
    logic            tick;        // timer increment
    logic [CH_N-1:0] spec;        // special event per channel
    logic            spec_hit;    // any special event
    logic [CH_N-1:0] match;       // compare equality
    logic [CH_N-1:0] cap_ev;      // capture events
    logic [CH_N-1:0] rise;        // pin rising edges
    logic [CH_N-1:0] fall;        // pin falling edges
    logic [7:0]      rd_val;      // read mux output

    assign any_rst = !rst_n_i || oth_rst_i;
    assign wr_lo   = wr_i && (addr_i == A_CNT_LO);
    assign wr_hi   = wr_i && (addr_i == A_CNT_HI);

    // prescale ratio 1, 2, 4 or 8 as a mask on the counter
    always_comb
    begin
        case (tctl_q[TC_PS +: 2])
            2'h0:    ps_mask = 3'h0;
            2'h1:    ps_mask = 3'h1;
            2'h2:    ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    end

    // external clock always goes through the synchroniser, so the
    // sync control bit is stored only; no async counting exists here
    cct_pin_sync u_ext_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .pin_i   (t_ext_i),
        .rise_o  (ext_rise),
        .fall_o  ()
    );

    assign raw_evt = tctl_q[TC_RUN] && (tctl_q[TC_SRC] ? ext_rise : 1'b1);
    assign psc_hit = ((psc_q & ps_mask) == ps_mask);
    assign tick    = raw_evt && psc_hit;
    assign spec_hit = |spec;

    // timer control: only power-on/brown-out clears it
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            tctl_q <= R_CTL;
        else if (wr_i && addr_i == A_TCTL)
            tctl_q <= wdata_i[5:0];
    end

    // prescaler counter
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            psc_q <= 3'h0;
        else if (wr_lo || wr_hi)
            psc_q <= 3'h0;
        else if (raw_evt)
            psc_q <= psc_hit ? 3'h0 : psc_q + 3'h1;
    end

    // count has no reset branch on purpose: only a special event or a rollover
    // zeroes it, so it powers up undefined until written
    always_ff @(posedge clock_i)
    begin
        if (wr_lo)
            cnt_q[7:0] <= wdata_i;
        else if (wr_hi)
            cnt_q[15:8] <= wdata_i;
        else if (spec_hit)
            cnt_q <= CNT_ZERO;
        else if (tick)
            cnt_q <= cnt_q + 16'h0001;
    end

    // overflow flag; a special reset is not a rollover
    always_ff @(posedge clock_i)
    begin
        if (any_rst)
            tovf_q <= 1'b0;
        else if (tick && cnt_q == CNT_TOP && !spec_hit
                 && !wr_lo && !wr_hi)
            tovf_q <= 1'b1;
        else if (wr_i && addr_i == A_FLAGS)
            tovf_q <= wdata_i[FLG_TOVF];
    end

    // overflow enable and port direction/latch registers
    always_ff @(posedge clock_i)
    begin
        if (any_rst)
        begin
            tovf_en_q <= 1'b0;
            dir_q     <= R_DIR;
            latch_q   <= 2'h0;
        end
        else if (wr_i)
        begin
            if (addr_i == A_EN)
                tovf_en_q <= wdata_i[FLG_TOVF];
            if (addr_i == A_DIR)
                dir_q <= wdata_i[1:0];
            if (addr_i == A_LATCH)
                latch_q <= wdata_i[1:0];
        end
    end

    // per-channel logic
    for (genvar c = 0; c < CH_N; c++)
    begin : g_ch
        cct_fn_t    fn;       // function class of this channel
        logic       ctl_wr;   // control register write
        logic       mode_chg; // write changes the mode
        logic [3:0] mode;     // current mode code

        assign mode     = ctl_q[c][3:0];
        assign fn       = cct_fn_of(mode);
        assign ctl_wr   = wr_i && (addr_i == CH_CTL_A[c]);
        assign mode_chg = ctl_wr && (wdata_i[3:0] != mode);
        assign match[c] = (fn == CCT_FN_CMP) && (cnt_q == val_q[c]);
        assign spec[c]  = match[c] && (mode == M_CMP_SPEC);

        // the pin is sampled even when driven by us, so a latch write
        // that makes a chosen edge is captured like an outside edge
        cct_pin_sync u_sync (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .pin_i   (ch_pin_i[c]),
            .rise_o  (rise[c]),
            .fall_o  (fall[c])
        );

        cct_edge_presc u_presc (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .mode_i  (mode),
            .rise_i  (rise[c]),
            .fall_i  (fall[c]),
            .event_o (cap_ev[c])
        );

        // control register; duty lsbs are stored in every mode
        always_ff @(posedge clock_i)
        begin
            if (any_rst)
                ctl_q[c] <= R_CTL;
            else if (ctl_wr)
                ctl_q[c] <= wdata_i[5:0];
        end

        // value pair: capture beats a same-cycle software write
        always_ff @(posedge clock_i)
        begin
            if (!rst_n_i)
                val_q[c] <= CNT_ZERO;
            else if (cap_ev[c] && fn == CCT_FN_CAP)
                val_q[c] <= cnt_q;
            else if (wr_i && addr_i == CH_VLO_A[c])
                val_q[c][7:0] <= wdata_i;
            else if (wr_i && addr_i == CH_VHI_A[c])
                val_q[c][15:8] <= wdata_i;
        end

        // match edge so a stopped timer flags only once
        always_ff @(posedge clock_i)
        begin
            if (!rst_n_i)
                match_q[c] <= 1'b0;
            else
                match_q[c] <= match[c];
        end

        // channel flag; hardware set wins over software clear
        always_ff @(posedge clock_i)
        begin
            if (any_rst)
                flag_q[c] <= 1'b0;
            else if ((cap_ev[c] && fn == CCT_FN_CAP)
                     || (match[c] && !match_q[c]))
                flag_q[c] <= 1'b1;
            else if (wr_i && addr_i == CH_FLG_A[c])
                flag_q[c] <= wdata_i[CH_FLG_B[c]];
        end

        // channel enable, gates nothing inside this block
        always_ff @(posedge clock_i)
        begin
            if (any_rst)
                en_q[c] <= 1'b0;
            else if (wr_i && addr_i == CH_EN_A[c])
                en_q[c] <= wdata_i[CH_FLG_B[c]];
        end

        // compare output; entering clear mode from any mode but off starts high so the
        // match has something to pull down
        always_ff @(posedge clock_i)
        begin
            if (any_rst || mode == M_OFF)
                out_q[c] <= 1'b0;
            else if (mode_chg)
                out_q[c] <= (wdata_i[3:0] == M_CMP_CLR);
            else if (match[c] && !match_q[c] && mode == M_CMP_SET)
                out_q[c] <= 1'b1;
            else if (match[c] && !match_q[c] && mode == M_CMP_CLR)
                out_q[c] <= 1'b0;
        end

        // pin drive: compare set/clear modes own the pin level,
        // flag-only and other modes leave it to the port latch
        always_ff @(posedge clock_i)
        begin
            if (!rst_n_i)
            begin
                pin_q[c] <= 1'b0;
                oe_q[c]  <= 1'b0;
            end
            else
            begin
                oe_q[c]  <= !dir_q[c];
                if (mode == M_CMP_SET || mode == M_CMP_CLR)
                    pin_q[c] <= out_q[c];
                else
                    pin_q[c] <= latch_q[c];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        case (addr_i)
            A_FLAGS:   rd_val = {5'h0, flag_q[0], 1'b0, tovf_q};
            A_FLAGS2:  rd_val = {7'h0, flag_q[1]};
            A_EN:      rd_val = {5'h0, en_q[0], 1'b0, tovf_en_q};
            A_EN2:     rd_val = {7'h0, en_q[1]};
            A_CNT_LO:  rd_val = cnt_q[7:0];
            A_CNT_HI:  rd_val = cnt_q[15:8];
            A_TCTL:    rd_val = {2'h0, tctl_q};
            A_CH1_CTL: rd_val = {2'h0, ctl_q[0]};
            A_CH2_CTL: rd_val = {2'h0, ctl_q[1]};
            A_CH1_VLO: rd_val = val_q[0][7:0];
            A_CH1_VHI: rd_val = val_q[0][15:8];
            A_CH2_VLO: rd_val = val_q[1][7:0];
            A_CH2_VHI: rd_val = val_q[1][15:8];
            A_DIR:     rd_val = {6'h0, dir_q};
            A_LATCH:   rd_val = {6'h0, latch_q};
            default:   rd_val = R_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            rdata_q <= R_ZERO;
        else if (rd_i)
            rdata_q <= rd_val;
        else
            rdata_q <= R_ZERO;
    end

    assign rdata_o     = rdata_q;
    assign ch_pin_o    = pin_q;
    assign ch_pin_oe_o = oe_q;

endmodule : cct_top

`default_nettype wire

//--- testbench/cct_top_checker.sv
/* assertions on the register port and pin enables of cct_top.
   assumes one clock and a master that never raises both strobes. */
`timescale 1ns/1ps
`default_nettype none
module cct_top_checker
    import cct_pkg::*;
(
    input wire logic            clock_i,
    input wire logic            rst_n_i,
    input wire logic            oth_rst_i,
    input wire logic [7:0]      addr_i,
    input wire logic [7:0]      wdata_i,
    input wire logic            wr_i,
    input wire logic            rd_i,
    input wire logic [7:0]      rdata_o,
    input wire logic            t_ext_i,
    input wire logic [CH_N-1:0] ch_pin_i,
    input wire logic [CH_N-1:0] ch_pin_o,
    input wire logic [CH_N-1:0] ch_pin_oe_o
);
    logic [7:0] tc_q; // shadow of timer control
    logic [5:0] m1_q; // shadow of channel one control
    logic [3:0] m2_q; // channel two mode
    logic       idle; // count moves only by writes
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // timer control ignores the other reset
    always_ff @(posedge clock_i)
        if (!rst_n_i) tc_q <= 8'h00;
        else if (wr_i && addr_i == A_TCTL) tc_q <= wdata_i;
    // channel controls clear on either reset
    always_ff @(posedge clock_i)
        if (!rst_n_i || oth_rst_i) {m1_q, m2_q} <= 10'h000;
        else if (wr_i && addr_i == A_CH1_CTL) m1_q <= wdata_i[5:0];
        else if (wr_i && addr_i == A_CH2_CTL) m2_q <= wdata_i[3:0];
    // a running timer or a special event could move the count
    assign idle = !tc_q[0] && m1_q[3:0] != M_CMP_SPEC && m2_q != M_CMP_SPEC;
    a_rdata_idle:
        assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    a_unmapped_zero:
        assert property (rd_i && addr_i == 8'h40 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_tctl_kept:
        assert property (rd_i && addr_i == A_TCTL |=> rdata_o == {2'b00, tc_q[5:0]})
        else $error("timer control read wrong");
    a_ctl_upper_zero:
        assert property (rd_i && addr_i == A_CH1_CTL && !oth_rst_i |=> rdata_o == {2'b00, m1_q})
        else $error("channel control read wrong");
    a_flag_unused:
        assert property (rd_i && addr_i == A_FLAGS |=> (rdata_o & 8'hFA) == 8'h00)
        else $error("unused flag bit set");
    a_count_wr_rd:
        assert property (wr_i && addr_i == A_CNT_LO && idle ##1 !wr_i
            ##1 rd_i && addr_i == A_CNT_LO |=> rdata_o == $past(wdata_i, 3))
            else $error("count byte lost");
    a_oe_follows:
        assert property (wr_i && addr_i == A_DIR ##1 !(wr_i && addr_i == A_DIR) && !oth_rst_i
            |=> ch_pin_oe_o == ~$past(wdata_i[1:0], 2)) else $error("pin enable wrong");
    a_oth_rst_oe:
        assert property (oth_rst_i |=> ##1 ch_pin_oe_o == 2'b00) else $error("pin driven");
    c_flag: cover property (rd_i && addr_i == A_FLAGS ##1 rdata_o[2]);
    c_pin: cover property ($rose(ch_pin_o[0]));
    c_spec: cover property (m2_q == M_CMP_SPEC && tc_q[0]);
endmodule : cct_top_checker
bind cct_top cct_top_checker i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .oth_rst_i(oth_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .t_ext_i(t_ext_i), .ch_pin_i(ch_pin_i),
    .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o));
`default_nettype wire

//--- testbench/cct_edge_src.sv
/* pin-side edge source for the channel pins.
   assumes the bench resolves the wire while the block drives it. */
`timescale 1ns/1ps
`default_nettype none
module cct_edge_src
(
    input  wire logic       clock_i, // core clock
    input  wire logic       rst_n_i, // sync reset, active low
    input  wire logic [1:0] tog_i,   // one-cycle toggle request
    input  wire logic       slow_i,  // answer three cycles late
    output logic      [1:0] lvl_o    // level offered to the pins
);
    logic [1:0] d1_q, d2_q, d3_q; // late toggle pipe
    // pins idle low; slow toggles land three cycles late
    always_ff @(posedge clock_i)
    begin
        d1_q <= slow_i ? tog_i : 2'b00;
        d2_q <= d1_q;
        d3_q <= d2_q;
        if (!rst_n_i) lvl_o <= 2'b00;
        else lvl_o <= lvl_o ^ d3_q ^ (slow_i ? 2'b00 : tog_i);
    end
endmodule : cct_edge_src
`default_nettype wire

//--- testbench/cct_top_test.sv
/* self-checking bench for cct_top: register master, pin source.
   assumes the checker binds itself to the block. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module cct_top_test
    import cct_pkg::*;
    ;
    logic       clock_i = 1'b0, rst_n_i = 1'b0, oth_rst_i = 1'b0; // clock, resets
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;         // register port
    logic       wr_i = 1'b0, rd_i = 1'b0, slow = 1'b0;            // strobes, slow source
    logic [1:0] pin_o, pin_oe, pin_w, lvl, tog = 2'b00;           // pin wire parts
    int         error_cnt = 0, tests_run = 0;                     // mismatches, checks
    always #2.5 clock_i = ~clock_i;
    // the block wins the wire while it drives
    assign pin_w = (pin_oe & pin_o) | (~pin_oe & lvl);
    cct_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .oth_rst_i(oth_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .t_ext_i(1'b0), .ch_pin_i(pin_w), .ch_pin_o(pin_o), .ch_pin_oe_o(pin_oe));
    cct_edge_src i_src (.clock_i(clock_i), .rst_n_i(rst_n_i), .tog_i(tog),
        .slow_i(slow), .lvl_o(lvl));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe
    task automatic rdv(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rdv
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        rdv(a, v);
        `CHK(n, e, v)
    endtask : rd
    // toggle one source pin, then let the synchroniser settle
    task automatic flip(input int b, input logic sl);
        @(posedge clock_i);
        tog[b] <= 1'b1;
        slow <= sl;
        @(posedge clock_i);
        tog[b] <= 1'b0;
        repeat (10) @(posedge clock_i);
    endtask : flip
    task automatic t_regs;
        rd(A_TCTL, 8'h00, "tctl por");
        rd(A_CH2_CTL, 8'h00, "ch2 ctl");
        rd(8'h40, 8'h00, "unmapped");
        wr(A_TCTL, 8'hF2);
        wr(A_CH1_CTL, 8'hFF);
        wr(A_CNT_HI, 8'hA5);
        wr(A_CNT_LO, 8'h5A);
        rd(A_CNT_LO, 8'h5A, "cnt lo");
        rd(A_CH1_CTL, 8'h3F, "ch1 ctl");
        @(posedge clock_i);
        oth_rst_i <= 1'b1;
        @(posedge clock_i);
        oth_rst_i <= 1'b0;
        rd(A_TCTL, 8'h32, "tctl other");
        rd(A_CNT_HI, 8'hA5, "cnt other");
        @(posedge clock_i) rst_n_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(A_TCTL, 8'h00, "tctl por2");
        rd(A_CNT_LO, 8'h5A, "cnt por");
        $display("test regs done");
    endtask : t_regs
    task automatic t_capture;
        wr(A_DIR, 8'h03);
        wr(A_CNT_HI, 8'h12);
        wr(A_CNT_LO, 8'h34);
        wr(A_CH1_CTL, {4'h0, M_CAP_FALL});
        wr(A_FLAGS, 8'h00);
        flip(0, 1'b0);
        rd(A_FLAGS, 8'h00, "rise ignored");
        flip(0, 1'b1);
        rd(A_FLAGS, 8'h04, "fall flag");
        rd(A_CH1_VLO, 8'h34, "cap lo");
        rd(A_CH1_VHI, 8'h12, "cap hi");
        wr(A_CH1_CTL, {4'h0, M_CAP_RISE});
        wr(A_FLAGS, 8'h00);
        flip(0, 1'b0);
        flip(0, 1'b0);
        wr(A_CNT_LO, 8'h9A);
        flip(0, 1'b1);
        rd(A_CH1_VLO, 8'h9A, "overwrite");
        for (int m = 0; m < 2; m++)
        begin
            wr(A_CH1_CTL, m ? {4'h0, M_CAP_R16} : {4'h0, M_CAP_R4});
            wr(A_FLAGS, 8'h00);
            flip(0, 1'b0);
            for (int k = 1; k < (m ? 16 : 4); k++)
            begin
                flip(0, 1'b0);
                flip(0, 1'b0);
            end
            rd(A_FLAGS, 8'h00, "early");
            flip(0, 1'b0);
            rd(A_FLAGS, 8'h04, "nth rise");
        end
        $display("test capture done");
    endtask : t_capture
    task automatic t_compare;
        logic [3:0] md [3] = '{M_CMP_CLR, M_CMP_SW, M_CMP_SET};
        logic       ex [3] = '{1'b0, 1'b0, 1'b1};
        wr(A_CH1_VLO, 8'h10);
        wr(A_DIR, 8'h02);
        for (int i = 0; i < 3; i++)
        begin
            wr(A_CNT_LO, 8'h00);
            wr(A_CH1_CTL, {4'h0, md[i]});
            wr(A_FLAGS, 8'h00);
            wr(A_CNT_LO, 8'h10);
            repeat (2) @(posedge clock_i);
            rd(A_FLAGS, 8'h04, "match flag");
            `CHK("pin level", ex[i], pin_o[0])
        end
        wr(A_CH1_CTL, 8'h00);
        rd(A_FLAGS, 8'h04, "flag kept");
        `CHK("idle pin", 1'b0, pin_o[0])
        wr(A_CH1_CTL, {4'h0, M_CAP_RISE});
        wr(A_FLAGS, 8'h00);
        wr(A_LATCH, 8'h01);
        repeat (6) @(posedge clock_i);
        rd(A_FLAGS, 8'h04, "latch edge");
        wr(A_CH1_CTL, 8'h00);
        $display("test compare done");
    endtask : t_compare
    task automatic t_special;
        logic [7:0] v;
        wr(A_CNT_HI, 8'hFF);
        wr(A_CNT_LO, 8'hFE);
        wr(A_FLAGS, 8'h00);
        wr(A_TCTL, 8'h01);
        repeat (8) @(posedge clock_i);
        wr(A_TCTL, 8'h00);
        rd(A_FLAGS, 8'h01, "overflow");
        wr(A_FLAGS, 8'h00);
        wr(A_CNT_LO, 8'h00);
        wr(A_CH2_VLO, 8'h05);
        wr(A_CH2_CTL, {4'h0, M_CMP_SPEC});
        wr(A_FLAGS2, 8'h00);
        wr(A_TCTL, 8'h01);
        repeat (40) @(posedge clock_i);
        wr(A_TCTL, 8'h00);
        rd(A_CNT_HI, 8'h00, "period hi");
        rdv(A_CNT_LO, v);
        `CHK("period lo", 1'b1, v <= 8'h05)
        rd(A_FLAGS, 8'h00, "no overflow");
        rd(A_FLAGS2, 8'h01, "event flag");
        $display("test special done");
    endtask : t_special
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_capture();
        t_compare();
        t_special();
        tally_and_finish();
    end
    // cut a hang short well past the expected run
    initial
    begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        $display("Error watchdog expected finish seen hang");
        tally_and_finish();
    end
endmodule : cct_top_test
`default_nettype wire
